// file: rtl/sbr_pkg.sv
// Constants and types shared by both ends of the bank/row/read link.
// Assumes one 200 MHz system clock on each end and a link clock made by the controller.
package sbr_pkg;

  // --------------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------------
  localparam int BANKS      = 8;
  localparam int BANK_W     = 3;
  localparam int ROW_W      = 14;
  localparam int COL_W      = 11;
  localparam int DQ_W       = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PIPE_W     = 12;

  // --------------------------------------------------------------------------
  // Address bit positions
  // --------------------------------------------------------------------------
  localparam int AP_BIT   = 10;
  localparam int CHOP_BIT = 12;

  // --------------------------------------------------------------------------
  // Timing, in link clock cycles unless noted; CK_HALF counts system clock cycles, BEATS_FULL and BEATS_CHOP count data beats
  // --------------------------------------------------------------------------
  localparam logic [2:0] CK_HALF     = 3'h4;
  localparam logic [3:0] COL_LAT     = 4'h6;
  localparam logic [3:0] TRP_CK      = 4'h9;
  localparam logic [2:0] COLUMN_COMMAND_SPACING_CK     = 3'h4;
  localparam logic [3:0] BEATS_FULL  = 4'h8;
  localparam logic [3:0] BEATS_CHOP  = 4'h4;

  // --------------------------------------------------------------------------
  // Burst-length field of mode register zero
  // --------------------------------------------------------------------------
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;

  typedef enum logic [1:0] {
    OP_ACT = 2'b00,
    OP_PRE = 2'b01,
    OP_RD  = 2'b10,
    OP_NOP = 2'b11
  } sbr_op_t;

endpackage : sbr_pkg

// file: rtl/sbr_link_if.sv
// Pins between the memory controller and the memory device.
// Assumes the bench joins both ends through this interface; no clocking here.
`timescale 1ns/1ps
interface sbr_link_if;
  import sbr_pkg::*;

  logic              ck;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BANK_W-1:0] ba;
  logic [ROW_W-1:0]  addr;
  logic [DQ_W-1:0]   dq_o;
  logic              dq_oe_n;
  logic              dqs_o;
  logic              dqs_oe_n;

  modport ctrl (
    output ck, cs_n, ras_n, cas_n, we_n, ba, addr,
    input  dq_o, dq_oe_n, dqs_o, dqs_oe_n
  );

  modport dram (
    input  ck, cs_n, ras_n, cas_n, we_n, ba, addr,
    output dq_o, dq_oe_n, dqs_o, dqs_oe_n
  );

endinterface : sbr_link_if

// file: rtl/sbr_device.sv
// Memory device end: bank/row tracking and read bursts with strobe.
// Assumes the controller makes the link clock and keeps its own timing duties.
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Read data FIFO
// ----------------------------------------------------------------------------
module sbr_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_reg != (AW + 1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(D - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(D - 1)) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : sbr_fifo

// ----------------------------------------------------------------------------
// Device end
// ----------------------------------------------------------------------------
module sbr_device
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // Link
  sbr_link_if.dram                LNK,
  // Mode and loop status
  input  wire logic [1:0]         MODE_BL,
  input  wire logic               AL_ON,
  input  wire logic               DLL_LOCKED,
  // Read data source
  input  wire logic [DQ_W-1:0]    RD_DATA,
  input  wire logic               RD_VALID,
  output logic                    RD_READY,
  // Read notice
  output logic                    RD_REQ,
  output logic [BANK_W-1:0]       RD_BANK,
  output logic [ROW_W-1:0]        RD_ROW,
  output logic [COL_W-1:0]        RD_COL,
  output logic                    RD_FULL,
  // Status
  output logic [BANKS-1:0]        BANK_OPEN,
  output logic                    PROTO_ERR
);
  localparam int PIN_W = 4 + BANK_W + ROW_W;

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detect
  // --------------------------------------------------------------------------
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic             ck_s1_reg;
  logic             ck_s2_reg;
  logic             ck_d_reg;
  logic             rise;
  logic             fall;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      ck_s1_reg  <= 1'b0;
      ck_s2_reg  <= 1'b0;
      ck_d_reg   <= 1'b0;
    end else begin
      pin_s1_reg <= {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n, LNK.ba, LNK.addr};
      pin_s2_reg <= pin_s1_reg;
      ck_s1_reg  <= LNK.ck;
      ck_s2_reg  <= ck_s1_reg;
      ck_d_reg   <= ck_s2_reg;
    end
  end

  assign rise = ck_s2_reg & ~ck_d_reg;
  assign fall = ~ck_s2_reg & ck_d_reg;

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BANK_W-1:0] ba;
  logic [ROW_W-1:0]  a;
  logic              is_act;
  logic              is_pre;
  logic              is_rd;
  logic              rd_ok;
  logic [BANKS-1:0]  open_reg;
  logic [BANKS-1:0][ROW_W-1:0] row_reg;
  logic [BANKS-1:0][3:0]       trp_reg;

  assign {cs_n, ras_n, cas_n, we_n, ba, a} = pin_s2_reg;
  assign is_act = rise & ~cs_n & ~ras_n & cas_n & we_n;
  assign is_pre = rise & ~cs_n & ~ras_n & cas_n & ~we_n;
  assign is_rd  = rise & ~cs_n & ras_n & ~cas_n & we_n;
  assign rd_ok  = is_rd & open_reg[ba] & DLL_LOCKED;

  // --------------------------------------------------------------------------
  // Per-bank state
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        open_reg[g] <= 1'b0;
        row_reg[g]  <= '0;
        trp_reg[g]  <= '0;
      end else if (is_pre && (a[AP_BIT] || ba == BANK_W'(g))) begin
        open_reg[g] <= 1'b0;
        trp_reg[g]  <= TRP_CK;
      end else if (rd_ok && a[AP_BIT] && ba == BANK_W'(g)) begin
        open_reg[g] <= 1'b0;
        trp_reg[g]  <= TRP_CK;
      end else begin
        if (is_act && ba == BANK_W'(g) && !open_reg[g] && trp_reg[g] == '0) begin
          open_reg[g] <= 1'b1;
          row_reg[g]  <= a;
        end
        if (rise && trp_reg[g] != '0) begin
          trp_reg[g] <= trp_reg[g] - 1'b1;
        end
      end
    end
  end

  assign BANK_OPEN = open_reg;

  // --------------------------------------------------------------------------
  // Protocol error flag
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PROTO_ERR <= 1'b0;
    end else begin
      PROTO_ERR <= (is_act & (open_reg[ba] | (trp_reg[ba] != '0))) | (is_rd & ~rd_ok);
    end
  end

  // --------------------------------------------------------------------------
  // Burst length and latency
  // --------------------------------------------------------------------------
  logic       full;
  logic [3:0] rl;

  assign full = (MODE_BL == BL_FIXED8) | ((MODE_BL == BL_OTF) & a[CHOP_BIT]);
  assign rl   = AL_ON ? (COL_LAT + COL_LAT - 4'h1) : COL_LAT;

  // --------------------------------------------------------------------------
  // Read notice to the data source
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RD_REQ  <= 1'b0;
      RD_BANK <= '0;
      RD_ROW  <= '0;
      RD_COL  <= '0;
      RD_FULL <= 1'b0;
    end else begin
      RD_REQ <= rd_ok;
      if (rd_ok) begin
        RD_BANK <= ba;
        RD_ROW  <= row_reg[ba];
        // column skips bits ten and twelve
        RD_COL  <= {a[11], a[9:0]};
        RD_FULL <= full;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Latency pipe, one slot per link cycle
  // --------------------------------------------------------------------------
  logic [PIPE_W-1:0] pv_reg;
  logic [PIPE_W-1:0] pf_reg;
  logic [PIPE_W-1:0] pv_next;
  logic [PIPE_W-1:0] pf_next;
  logic              start;

  assign start = rise & pv_reg[0];

  always_comb begin
    pv_next = pv_reg >> 1;
    pf_next = pf_reg >> 1;
    if (rd_ok) begin
      pv_next[rl - 4'h1] = 1'b1;
      pf_next[rl - 4'h1] = full;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pv_reg <= '0;
      pf_reg <= '0;
    end else if (rise) begin
      pv_reg <= pv_next;
      pf_reg <= pf_next;
    end
  end

  // --------------------------------------------------------------------------
  // Beat engine
  // --------------------------------------------------------------------------
  logic            fifo_valid;
  logic [DQ_W-1:0] fifo_data;
  logic            beat;
  logic [3:0]      left_reg;
  logic            act_reg;
  logic            dqs_reg;
  logic [DQ_W-1:0] dq_reg;

  assign beat = start | ((rise | fall) & (left_reg != '0));

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      left_reg <= '0;
      act_reg  <= 1'b0;
      dqs_reg  <= 1'b0;
      dq_reg   <= '0;
    end else if (beat) begin
      act_reg  <= 1'b1;
      left_reg <= start ? ((pf_reg[0] ? BEATS_FULL : BEATS_CHOP) - 4'h1) : left_reg - 4'h1;
      dqs_reg  <= start ? 1'b1 : ~dqs_reg;
      dq_reg   <= fifo_valid ? fifo_data : '0;
    end else if (rise | fall) begin
      act_reg <= 1'b0;
      dqs_reg <= 1'b0;
    end
  end

  sbr_fifo #(
    .W (DQ_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (RD_VALID),
    .in_ready  (RD_READY),
    .in_data   (RD_DATA),
    .out_valid (fifo_valid),
    .out_ready (beat),
    .out_data  (fifo_data)
  );

  assign LNK.dq_o     = dq_reg;
  assign LNK.dqs_o    = dqs_reg;
  assign LNK.dq_oe_n  = ~act_reg;
  assign LNK.dqs_oe_n = ~act_reg;

endmodule : sbr_device

// file: rtl/sbr_host.sv
// Memory controller end: makes the link clock, issues commands, captures reads.
// Assumes the user offers one command at a time with valid and ready.
`timescale 1ns/1ps
module sbr_host
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // Link
  sbr_link_if.ctrl               LNK,
  // Command port
  input  wire logic              CMD_VALID,
  output logic                   CMD_READY,
  input  wire logic [1:0]        CMD_OP,
  input  wire logic [BANK_W-1:0] CMD_BANK,
  input  wire logic [ROW_W-1:0]  CMD_ADDR,
  output logic                   CMD_ERR,
  // Read data
  output logic                   RD_VALID,
  output logic [DQ_W-1:0]        RD_DATA,
  // Status
  output logic [BANKS-1:0]       BANK_OPEN
);
  // --------------------------------------------------------------------------
  // Link clock divider
  // --------------------------------------------------------------------------
  logic [2:0] div_reg;
  logic       ck_reg;
  logic       tick;
  logic       rise_en;
  logic       fall_en;

  assign tick    = (div_reg == CK_HALF - 3'h1);
  assign rise_en = tick & ~ck_reg;
  assign fall_en = tick & ck_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_reg <= '0;
      ck_reg  <= 1'b0;
    end else begin
      div_reg <= tick ? '0 : div_reg + 3'h1;
      if (tick) begin
        ck_reg <= ~ck_reg;
      end
    end
  end

  assign LNK.ck = ck_reg;

  // --------------------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------------------
  logic [BANKS-1:0]      open_reg;
  logic [BANKS-1:0][3:0] trp_reg;
  logic [2:0]            ccd_reg;
  logic                  wait_c;
  logic                  take;
  logic                  legal;
  logic                  go_act;
  logic                  go_pre;
  logic                  go_rd;

  assign wait_c    = ((CMD_OP == OP_RD) & (ccd_reg != '0)) |
                     ((CMD_OP == OP_ACT) & (trp_reg[CMD_BANK] != '0));
  assign CMD_READY = fall_en & ~wait_c;
  assign take      = CMD_VALID & CMD_READY;
  assign legal     = (CMD_OP == OP_PRE) | (CMD_OP == OP_NOP) |
                     ((CMD_OP == OP_ACT) & ~open_reg[CMD_BANK]) |
                     ((CMD_OP == OP_RD) & open_reg[CMD_BANK]);
  assign go_act    = take & legal & (CMD_OP == OP_ACT);
  assign go_pre    = take & (CMD_OP == OP_PRE);
  assign go_rd     = take & legal & (CMD_OP == OP_RD);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CMD_ERR <= 1'b0;
    end else begin
      CMD_ERR <= take & ~legal;
    end
  end

  // --------------------------------------------------------------------------
  // Bank tracking and spacing timers
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        open_reg[g] <= 1'b0;
        trp_reg[g]  <= '0;
      end else if ((go_pre && (CMD_ADDR[AP_BIT] || CMD_BANK == BANK_W'(g))) ||
                   (go_rd && CMD_ADDR[AP_BIT] && CMD_BANK == BANK_W'(g))) begin
        open_reg[g] <= 1'b0;
        trp_reg[g]  <= TRP_CK + 4'h1;
      end else begin
        if (go_act && CMD_BANK == BANK_W'(g)) begin
          open_reg[g] <= 1'b1;
        end
        if (rise_en && trp_reg[g] != '0) begin
          trp_reg[g] <= trp_reg[g] - 4'h1;
        end
      end
    end
  end

  assign BANK_OPEN = open_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ccd_reg <= '0;
    end else if (go_rd) begin
      ccd_reg <= COLUMN_COMMAND_SPACING_CK;
    end else if (rise_en && ccd_reg != '0) begin
      ccd_reg <= ccd_reg - 3'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Command pins, changed on falling link edge
  // --------------------------------------------------------------------------
  logic       issue;
  logic [3:0] cmd_pins;

  assign issue = take & legal & (CMD_OP != OP_NOP);

  always_comb begin
    unique case (sbr_op_t'(CMD_OP))
      OP_ACT:  cmd_pins = 4'h3;
      OP_PRE:  cmd_pins = 4'h2;
      OP_RD:   cmd_pins = 4'h5;
      OP_NOP:  cmd_pins = 4'h7;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= 4'hF;
      LNK.ba   <= '0;
      LNK.addr <= '0;
    end else if (fall_en) begin
      {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= issue ? {1'b0, cmd_pins[2:0]} : 4'hF;
      LNK.ba   <= issue ? CMD_BANK : '0;
      LNK.addr <= issue ? CMD_ADDR : '0;
    end
  end

  // --------------------------------------------------------------------------
  // Read capture on strobe edges
  // --------------------------------------------------------------------------
  logic [DQ_W+1:0] in_s1_reg;
  logic [DQ_W+1:0] in_s2_reg;
  logic            dqs_d_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      in_s1_reg <= {2'h2, {DQ_W{1'b0}}};
      in_s2_reg <= {2'h2, {DQ_W{1'b0}}};
      dqs_d_reg <= 1'b0;
    end else begin
      in_s1_reg <= {LNK.dqs_oe_n, LNK.dqs_o, LNK.dq_o};
      in_s2_reg <= in_s1_reg;
      dqs_d_reg <= in_s2_reg[DQ_W];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RD_VALID <= 1'b0;
      RD_DATA  <= '0;
    end else begin
      RD_VALID <= ~in_s2_reg[DQ_W+1] & (in_s2_reg[DQ_W] != dqs_d_reg);
      if (~in_s2_reg[DQ_W+1] & (in_s2_reg[DQ_W] != dqs_d_reg)) begin
        RD_DATA <= in_s2_reg[DQ_W-1:0];
      end
    end
  end

endmodule : sbr_host

// file: tb/sbr_link_monitor.sv
// Checker for the pins between the host and device ends.
// Assumes one CLK domain; the bench places it beside the link interface.
`timescale 1ns/1ps
module sbr_link_monitor
  import sbr_pkg::*;
(
  // Clock and reset
  input wire logic              CLK,
  input wire logic              RST_N,
  // Link
  input wire logic              ck,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0]  addr,
  input wire logic [DQ_W-1:0]   dq_o,
  input wire logic              dq_oe_n,
  input wire logic              dqs_o,
  input wire logic              dqs_oe_n
);
  logic       rd_cmd;
  logic       rd_start;
  logic       rd_q_reg;
  logic [7:0] gap_reg;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  assign rd_cmd   = !cs_n && ras_n && !cas_n && we_n;
  assign rd_start = rd_cmd && !rd_q_reg;

  // --------------------------------------------------------------------------
  // Cycles since last read command
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_q_reg <= 1'b0;
      gap_reg  <= 8'hFF;
    end else begin
      rd_q_reg <= rd_cmd;
      if (rd_start)
        gap_reg <= 8'h00;
      else if (gap_reg != 8'hFF)
        gap_reg <= gap_reg + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Link checks
  // --------------------------------------------------------------------------
  idle_pins_a: assert property (cs_n |-> ras_n && cas_n && we_n)
    else $error("command pins not idle");
  cmd_hold_a: assert property ($fell(cs_n) |=> (!cs_n && $stable({ba, addr, ras_n, cas_n, we_n}))[*7])
    else $error("command not held one link cycle");
  cmd_edge_a: assert property ($fell(cs_n) |-> $fell(ck))
    else $error("command not launched at link clock fall");
  ck_period_a: assert property ($rose(ck) |-> ck[*4] ##1 !ck[*4])
    else $error("link clock period wrong");
  rd_gap_a: assert property (rd_start |-> gap_reg >= 8'h1F)
    else $error("reads closer than four link cycles");
  strobe_idle_a: assert property (dqs_oe_n |-> !dqs_o)
    else $error("strobe high while released");
  burst_start_a: assert property ($fell(dqs_oe_n) |-> gap_reg <= 8'h6E)
    else $error("burst without recent read");
  beat_width_a: assert property ($rose(dqs_o) |-> dqs_o[*4] ##1 !dqs_o)
    else $error("strobe beat width wrong");
  data_edge_a: assert property (!dq_oe_n && !$past(dq_oe_n) && $changed(dq_o) |-> $changed(dqs_o))
    else $error("data moved off strobe edge");
endmodule : sbr_link_monitor

// file: tb/sdram_bank_row_read_control_tb_top.sv
// Bench joining the host and device ends across the link interface.
// Assumes both ends are design code; the bench plays user and data source.
`timescale 1ns/1ps
module sdram_bank_row_read_control_tb_top;
  import sbr_pkg::*;

  logic              clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
  logic [1:0]        cmd_op = OP_NOP, mode_bl = BL_OTF;
  logic [BANK_W-1:0] cmd_bank = '0, rd_bank, b;
  logic [ROW_W-1:0]  cmd_addr = '0, rd_row, row;
  logic              al_on = 1'b0, dll_locked = 1'b1, src_valid = 1'b0;
  logic              cmd_ready, cmd_err, h_rd_valid, src_ready, rd_req, rd_full, proto_err, perr_seen = 1'b0, e;
  logic [DQ_W-1:0]   h_rd_data, src_data = '0, got[$], exp_q[$];
  logic [BANKS-1:0]  h_open, d_open;
  logic [COL_W-1:0]  rd_col;
  int                errors = 0, samples_checked = 0, cyc = 0, t_take, t_first, t0, lat[4], nb, nreq = 0;
  integer            seed = 32'hF1C29548;

  sbr_link_if lnk ();
  sbr_host sbr_host_i (.CLK(clk), .RST_N(rst_n), .LNK(lnk), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_OP(cmd_op), .CMD_BANK(cmd_bank), .CMD_ADDR(cmd_addr), .CMD_ERR(cmd_err), .RD_VALID(h_rd_valid),
    .RD_DATA(h_rd_data), .BANK_OPEN(h_open));
  sbr_device sbr_device_i (.CLK(clk), .RST_N(rst_n), .LNK(lnk), .MODE_BL(mode_bl), .AL_ON(al_on),
    .DLL_LOCKED(dll_locked), .RD_DATA(src_data), .RD_VALID(src_valid), .RD_READY(src_ready), .RD_REQ(rd_req),
    .RD_BANK(rd_bank), .RD_ROW(rd_row), .RD_COL(rd_col), .RD_FULL(rd_full), .BANK_OPEN(d_open),
    .PROTO_ERR(proto_err));
  sbr_link_monitor sbr_link_monitor_i (.CLK(clk), .RST_N(rst_n), .ck(lnk.ck), .cs_n(lnk.cs_n),
    .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr), .dq_o(lnk.dq_o),
    .dq_oe_n(lnk.dq_oe_n), .dqs_o(lnk.dqs_o), .dqs_oe_n(lnk.dqs_oe_n));

  always #2.5 clk = ~clk;

  // Beat capture on the host side
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (h_rd_valid === 1'b1) begin
      if (got.size() == 0)
        t_first = cyc;
      got.push_back(h_rd_data);
    end
    if (proto_err === 1'b1)
      perr_seen = 1'b1;
    if (rd_req === 1'b1)
      nreq = nreq + 1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic issue(input logic [1:0] op, input logic [BANK_W-1:0] bk, input logic [ROW_W-1:0] a);
    int n = 0;
    cmd_op = op;
    cmd_bank = bk;
    cmd_addr = a;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400)
      errors++;
    @(negedge clk);
    t_take = cyc;
    cmd_valid = 1'b0;
    e = cmd_err;
    @(negedge clk);
    e = e | cmd_err;
  endtask : issue

  task automatic push(input int n);
    repeat (n) begin
      src_data = 16'($random(seed));
      src_valid = 1'b1;
      while (src_ready !== 1'b1) @(negedge clk);
      exp_q.push_back(src_data);
      @(negedge clk);
    end
    src_valid = 1'b0;
  endtask : push

  task automatic beats(input int n, input int w);
    repeat (w) @(negedge clk);
    chk(got.size(), n);
    for (int i = 0; i < n; i++) chk(got[i], exp_q.pop_front());
  endtask : beats

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (10000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    logic [COL_W-1:0] col;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk({h_open, d_open}, 16'h0000);
    b = 3'($random(seed));
    row = 14'($random(seed));
    push(8);
    chk(src_ready, 1'b0);
    issue(OP_ACT, b, row);
    chk(e, 1'b0);
    repeat (40) @(negedge clk);
    chk({h_open[b], d_open[b]}, 2'b11);
    issue(OP_ACT, b, row ^ 14'h0001);
    chk(e, 1'b1);
    issue(OP_RD, b ^ 3'h1, 14'h1000);
    chk(e, 1'b1);
    // Burst length table, latency alternating
    for (int i = 0; i < 4; i++) begin
      mode_bl = (i == 2) ? BL_FIXED8 : (i == 3) ? 2'h2 : BL_OTF;
      al_on = i[0];
      nb = (i == 0 || i == 2) ? 8 : 4;
      if (i > 0)
        push(nb);
      col = 11'($random(seed));
      got.delete();
      issue(OP_RD, b, {1'b0, (i == 0 || i == 3), col[10], 1'b0, col[9:0]});
      beats(nb, 180);
      lat[i] = t_first - t_take;
      chk(rd_col, col);
      chk({rd_bank, rd_full}, {b, nb == 8});
    end
    chk(rd_row, row);
    chk(lat[1] - lat[0], 40);
    chk(lat[3] - lat[2], 40);
    // Auto precharge read then seamless read to another bank
    mode_bl = BL_OTF;
    issue(OP_ACT, b ^ 3'h1, row);
    push(8);
    got.delete();
    issue(OP_RD, b, 14'h1400);
    issue(OP_RD, b ^ 3'h1, 14'h1000);
    chk(e, 1'b0);
    push(8);
    beats(16, 150);
    chk(h_open[b], 1'b0);
    issue(OP_PRE, b, 14'h0000);
    chk(e, 1'b0);
    issue(OP_PRE, b ^ 3'h1, 14'h0000);
    chk(h_open[b ^ 3'h1], 1'b0);
    repeat (40) @(negedge clk);
    issue(OP_PRE, b ^ 3'h1, 14'h0000);
    t0 = t_take;
    issue(OP_ACT, b ^ 3'h1, row);
    chk(t_take - t0 >= 80, 1'b1);
    issue(OP_ACT, b ^ 3'h2, row);
    issue(OP_PRE, 3'h0, 14'h0400);
    repeat (40) @(negedge clk);
    chk({h_open, d_open}, 16'h0000);
    issue(OP_ACT, b, row);
    chk(perr_seen, 1'b0);
    dll_locked = 1'b0;
    perr_seen = 1'b0;
    got.delete();
    issue(OP_RD, b, 14'h1000);
    repeat (150) @(negedge clk);
    chk({perr_seen, 5'(got.size())}, 6'h20);
    chk(nreq, 6);
    tally_and_finish();
  end
endmodule : sdram_bank_row_read_control_tb_top
